// ==== hw/wdt_pkg.sv ====
// Shared constants for the watchdog device and its host-side controller
package wdt_pkg;

  // ****************************************************************
  // I/O port side
  // ****************************************************************
  localparam int IO_ADDR_W = 16;
  localparam int IO_DATA_W = 8;
  localparam logic [15:0] WD_PORT = 16'h0076;
  localparam logic [15:0] ALT_OFFSET = 16'h0004;
  localparam logic [7:0] FACTOR_OFF = 8'h00;
  // Factor layout: [7:6] mode, [5:3] must be zero, [2:0] period code
  localparam int MODE_HI = 7;
  localparam int MODE_LO = 6;
  localparam int PAD_HI = 5;
  localparam int PAD_LO = 3;
  localparam int CODE_HI = 2;
  localparam logic [1:0] MODE_RESET = 2'h2;
  localparam logic [1:0] MODE_INT = 2'h3;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int unsigned CLK_HZ = 20000000;
  localparam int unsigned UNIT_MS = 6000;
  localparam int unsigned HALF_UNIT_MS = UNIT_MS / 2;
  localparam int unsigned HALF_UNIT_CYCLES = HALF_UNIT_MS * (CLK_HZ / 1000);
  localparam int unsigned BLINK_MS = 250;
  localparam int unsigned BLINK_CYCLES = BLINK_MS * (CLK_HZ / 1000);
  localparam int unsigned RESET_PULSE_CYCLES = 16;
  localparam int HALF_W = 4;

  // ****************************************************************
  // Host controller register map (byte offsets on the AHB-Lite bus)
  // ****************************************************************
  localparam logic [7:0] REG_CMD = 8'h00;
  localparam logic [7:0] REG_BASE = 8'h04;
  localparam logic [7:0] REG_STATUS = 8'h08;
  localparam logic [7:0] REG_MASK = 8'h0c;
  localparam logic [7:0] REG_LAST = 8'h10;
  localparam int CMD_ALT_BIT = 8;
  localparam int ST_W = 3;
  localparam int ST_IRQ = 0;
  localparam int ST_RESET = 1;
  localparam int ST_SENT = 2;
  localparam logic [15:0] BASE_RESET = 16'h0000;

  typedef enum logic [3:0] {
    WD_OFF = 4'h1,
    WD_COUNT = 4'h2,
    WD_FIRE = 4'h4,
    WD_ALARM = 4'h8
  } wd_state_type;

endpackage

// ==== hw/wdt_if.sv ====
// Link between the watchdog device and the host that writes its port
`timescale 1ns/1ps
interface wdt_if;
  import wdt_pkg::*;
  logic [IO_ADDR_W-1:0] io_addr;
  logic [IO_DATA_W-1:0] io_wdata;
  logic io_wr;
  logic wd_irq;
  logic wd_reset;

  modport device (
    input io_addr,
    input io_wdata,
    input io_wr,
    output wd_irq,
    output wd_reset
  );

  modport host (
    output io_addr,
    output io_wdata,
    output io_wr,
    input wd_irq,
    input wd_reset
  );
endinterface

// ==== hw/wdt_device.sv ====
// Watchdog timer behind a write-only byte port decoded at WD_PORT and at base_port plus ALT_OFFSET
//
// The AHB-Lite register port is this design's own decision.
`timescale 1ns/1ps
module wdt_device #(
  parameter int unsigned HALF_CYCLES = wdt_pkg::HALF_UNIT_CYCLES,
  parameter int unsigned BLINK_CYCLES = wdt_pkg::BLINK_CYCLES,
  parameter int unsigned PULSE_CYCLES = wdt_pkg::RESET_PULSE_CYCLES
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Port written by the host
  wdt_if.device io,
  // Board side
  input wire logic [wdt_pkg::IO_ADDR_W-1:0] base_port,
  output logic led_out
);
  import wdt_pkg::*;

  localparam int PW = $clog2(HALF_CYCLES + 1);
  localparam int BW = $clog2(BLINK_CYCLES + 1);
  localparam int RW = $clog2(PULSE_CYCLES + 1);
  localparam logic [PW-1:0] PRESC_LAST = PW'(HALF_CYCLES - 1);
  localparam logic [BW-1:0] BLINK_LAST = BW'(BLINK_CYCLES - 1);
  localparam logic [RW-1:0] PULSE_LAST = RW'(PULSE_CYCLES - 1);

  // ****************************************************************
  // Period code to number of half units
  // ****************************************************************
  // Code 0 is half a unit, code n is n whole units.
  function automatic logic [HALF_W-1:0] half_limit(input logic [2:0] code);
    logic [HALF_W-1:0] lim;
    lim = (code == 3'h0) ? 4'h1 : {code, 1'b0};
    return lim;
  endfunction

  // ****************************************************************
  // Base port strap synchroniser
  // ****************************************************************
  logic [IO_ADDR_W-1:0] base_meta_q;
  logic [IO_ADDR_W-1:0] base_q;

  always_ff @(posedge core_clk)
  begin
    base_meta_q <= base_port;
    base_q <= base_meta_q;
  end

  // ****************************************************************
  // Write decode
  // ****************************************************************
  wire [IO_ADDR_W-1:0] alt_addr = IO_ADDR_W'(base_q + ALT_OFFSET);
  wire addr_main = (io.io_addr == WD_PORT);
  wire addr_alt = (io.io_addr == alt_addr);
  wire hit = io.io_wr && (addr_main || addr_alt);
  wire [1:0] wr_mode = io.io_wdata[MODE_HI:MODE_LO];
  wire pad_ok = (io.io_wdata[PAD_HI:PAD_LO] == 3'h0);
  wire [2:0] wr_code = io.io_wdata[CODE_HI:0];
  wire wr_reset = hit && pad_ok && (wr_mode == MODE_RESET);
  wire wr_int = hit && pad_ok && (wr_mode == MODE_INT);
  wire wr_enable = wr_reset || wr_int;
  // 00h and every undefined code land here
  wire wr_off = hit && !wr_enable;

  // ****************************************************************
  // Timebase
  // ****************************************************************
  wd_state_type state_q;
  wd_state_type state_d;
  logic [PW-1:0] presc_q;
  logic [HALF_W-1:0] half_q;
  logic [HALF_W-1:0] limit_q;
  logic int_mode_q;
  logic [RW-1:0] pulse_q;
  logic irq_q;
  logic irq_d;
  logic [BW-1:0] blink_cnt_q;
  logic blink_q;

  wire counting = (state_q == WD_COUNT);
  wire tick = counting && (presc_q == PRESC_LAST);
  wire expire = tick && (half_q == limit_q - 4'h1);
  wire pulse_done = (pulse_q == PULSE_LAST);

  // Prescaler restarts on an enabling write so each period is full
  always_ff @(posedge core_clk)
  begin
    if (rst || wr_enable || !counting || tick)
      presc_q <= '0;
    else
      presc_q <= presc_q + PW'(1);
  end

  always_ff @(posedge core_clk)
  begin
    if (rst || wr_enable || !counting)
      half_q <= '0;
    else if (tick)
      half_q <= half_q + 4'h1;
  end

  // Period and mode take effect on the very write that names them
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      limit_q <= 4'h1;
      int_mode_q <= 1'b0;
    end
    else if (wr_enable)
    begin
      limit_q <= half_limit(wr_code);
      int_mode_q <= wr_int;
    end
  end

  // ****************************************************************
  // Control state machine
  // ****************************************************************
  always_comb
  begin
    state_d = state_q;
    case (state_q)
      WD_OFF:
        if (wr_enable)
          state_d = WD_COUNT;
      WD_COUNT:
        if (wr_off)
          state_d = WD_OFF;
        else if (wr_enable)
          state_d = WD_COUNT;
        else if (expire)
          state_d = int_mode_q ? WD_ALARM : WD_FIRE;
      WD_FIRE:
        if (pulse_done)
          state_d = WD_OFF;
      WD_ALARM:
        if (wr_off)
          state_d = WD_OFF;
        else if (wr_enable)
          state_d = WD_COUNT;
      default:
        state_d = WD_OFF;
    endcase
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
      state_q <= WD_OFF;
    else
      state_q <= state_d;
  end

  // ****************************************************************
  // Expiry outputs
  // ****************************************************************
  // Pulse length is fixed; the system reset it causes clears us anyway
  always_ff @(posedge core_clk)
  begin
    if (rst || state_q != WD_FIRE)
      pulse_q <= '0;
    else if (!pulse_done)
      pulse_q <= pulse_q + RW'(1);
  end

  // Interrupt is a level held until the next write to the port.
  // Enabling interrupt mode from idle raises it at once.
  always_comb
  begin
    irq_d = irq_q;
    if (hit)
      irq_d = 1'b0;
    if (wr_int && state_q == WD_OFF)
      irq_d = 1'b1;
    if (expire && int_mode_q)
      irq_d = 1'b1;
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
      irq_q <= 1'b0;
    else
      irq_q <= irq_d;
  end

  assign io.wd_irq = irq_q;
  assign io.wd_reset = (state_q == WD_FIRE);

  // ****************************************************************
  // Activity LED
  // ****************************************************************
  always_ff @(posedge core_clk)
  begin
    if (rst || !counting)
    begin
      blink_cnt_q <= '0;
      blink_q <= 1'b0;
    end
    else if (blink_cnt_q == BLINK_LAST)
    begin
      blink_cnt_q <= '0;
      blink_q <= !blink_q;
    end
    else
      blink_cnt_q <= blink_cnt_q + BW'(1);
  end

  assign led_out = blink_q;

endmodule

// ==== hw/wdt_host.sv ====
// Host-side controller: AHB-Lite registers that drive the watchdog port
`timescale 1ns/1ps
module wdt_host (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Interrupt
  output logic irq,
  // Watchdog port
  wdt_if.host io
);
  import wdt_pkg::*;

  // ****************************************************************
  // Bus decode
  // ****************************************************************
  wire addr_phase = hsel && hready && htrans[1];
  wire [7:0] a_off = haddr[7:0];
  logic wr_pend_q;
  logic [7:0] wr_off_q;
  logic [15:0] base_q;
  logic [ST_W-1:0] status_q;
  logic [ST_W-1:0] mask_q;
  logic [7:0] last_q;
  logic irq_prev_q;
  logic [IO_ADDR_W-1:0] io_addr_q;
  logic [IO_DATA_W-1:0] io_wdata_q;
  logic io_wr_q;

  wire wr_cmd = wr_pend_q && (wr_off_q == REG_CMD);
  wire wr_base = wr_pend_q && (wr_off_q == REG_BASE);
  wire wr_stat = wr_pend_q && (wr_off_q == REG_STATUS);
  wire wr_mask = wr_pend_q && (wr_off_q == REG_MASK);
  wire [IO_ADDR_W-1:0] alt_addr = IO_ADDR_W'(base_q + ALT_OFFSET);
  wire [IO_ADDR_W-1:0] cmd_addr = hwdata[CMD_ALT_BIT] ? alt_addr : WD_PORT;
  wire irq_rise = io.wd_irq && !irq_prev_q;
  wire [ST_W-1:0] st_set = {io_wr_q, io.wd_reset, irq_rise};
  wire [ST_W-1:0] st_clr = wr_stat ? hwdata[ST_W-1:0] : '0;
  wire [31:0] rd_mux =
    (a_off == REG_BASE) ? {16'h0000, base_q} :
    (a_off == REG_STATUS) ? {{(32-ST_W){1'b0}}, status_q} :
    (a_off == REG_MASK) ? {{(32-ST_W){1'b0}}, mask_q} :
    (a_off == REG_LAST) ? {24'h000000, last_q} : 32'h00000000;

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      wr_pend_q <= 1'b0;
      wr_off_q <= 8'h00;
      hrdata <= 32'h00000000;
    end
    else
    begin
      wr_pend_q <= addr_phase && hwrite;
      wr_off_q <= a_off;
      if (addr_phase && !hwrite)
        hrdata <= rd_mux;
    end
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      base_q <= BASE_RESET;
      mask_q <= '0;
      last_q <= FACTOR_OFF;
      status_q <= '0;
      irq_prev_q <= 1'b0;
    end
    else
    begin
      if (wr_base)
        base_q <= hwdata[15:0];
      if (wr_mask)
        mask_q <= hwdata[ST_W-1:0];
      if (wr_cmd)
        last_q <= hwdata[7:0];
      // A new event wins over a clear in the same cycle
      status_q <= (status_q & ~st_clr) | st_set;
      irq_prev_q <= io.wd_irq;
    end
  end

  assign irq = |(status_q & mask_q);

  // ****************************************************************
  // Port write: one strobe per command write
  // ****************************************************************
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      io_wr_q <= 1'b0;
      io_addr_q <= WD_PORT;
      io_wdata_q <= FACTOR_OFF;
    end
    else
    begin
      io_wr_q <= wr_cmd;
      if (wr_cmd)
      begin
        io_addr_q <= cmd_addr;
        io_wdata_q <= hwdata[7:0];
      end
    end
  end

  assign io.io_wr = io_wr_q;
  assign io.io_addr = io_addr_q;
  assign io.io_wdata = io_wdata_q;

endmodule

// ==== verif/wdt_assertions.sv ====
// Concurrent checks on the link between host controller and watchdog
`timescale 1ns/1ps
module wdt_checker #(
  parameter int unsigned HALF_CYCLES = 20
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Port link
  input wire logic [wdt_pkg::IO_ADDR_W-1:0] io_addr,
  input wire logic [wdt_pkg::IO_DATA_W-1:0] io_wdata,
  input wire logic io_wr,
  input wire logic wd_irq,
  input wire logic wd_reset
);
  import wdt_pkg::*;
  // The last factor and the cycles since it; the host writes only addresses the device
  // accepts while its base register matches the strap, so every strobe counts
  logic [7:0] last_q;
  logic [31:0] cnt_q;
  logic [31:0] span;
  logic good;
  assign good = io_wdata[7] && io_wdata[5:3] == 3'h0;
  assign span = HALF_CYCLES * ((last_q[2:0] == 3'h0) ? 32'h1
    : {28'h0, last_q[2:0], 1'b0});
  always_ff @(posedge core_clk)
  begin
    if (rst || io_wr)
      cnt_q <= 32'h0;
    else
      cnt_q <= cnt_q + 32'h1;
  end
  always_ff @(posedge core_clk)
  begin
    if (rst)
      last_q <= 8'h00;
    else if (io_wr)
      last_q <= io_wdata;
  end
  default clocking dc @(posedge core_clk);
  endclocking
  default disable iff (rst);
  chk_quiet_after_reset:
    assert property ($fell(rst) |-> !wd_irq && !wd_reset)
    else $error("link output active after reset");
  chk_irq_on_enable:
    assert property (io_wr && good && io_wdata[6] && last_q == 8'h00
      |=> wd_irq) else $error("no interrupt at enable");
  chk_pulse_width:
    assert property ($rose(wd_reset) |-> wd_reset [*4] ##1 !wd_reset)
    else $error("reset pulse width wrong");
  chk_disable_quiet:
    assert property (io_wr && io_wdata == 8'h00 && !wd_reset
      |=> !wd_irq && !wd_reset) else $error("disable write ignored");
  chk_undefined_off:
    assert property (io_wr && !good && io_wdata != 8'h00 && !wd_reset
      |=> (!wd_irq && !wd_reset) [*2]) else $error("bad factor ran");
  chk_reset_expiry:
    assert property ($rose(wd_reset) |-> cnt_q == span)
    else $error("reset pulse at wrong time");
  chk_irq_expiry:
    assert property ($rose(wd_irq) |-> cnt_q <= 32'h1 || cnt_q == span)
    else $error("interrupt at wrong time");
  chk_reset_mode:
    assert property ($rose(wd_reset) |-> last_q[7:6] == MODE_RESET)
    else $error("reset pulse outside reset mode");
  chk_irq_mode:
    assert property ($rose(wd_irq) |-> last_q[7:6] == MODE_INT)
    else $error("interrupt outside interrupt mode");
endmodule

// ==== verif/testbench.sv ====
// Self-checking bench: host controller driving the watchdog device
`timescale 1ns/1ps
module testbench;
  import wdt_pkg::*;
  logic core_clk;
  logic rst;
  logic hsel;
  logic [31:0] haddr;
  logic [1:0] htrans;
  logic hwrite;
  logic [31:0] hwdata;
  logic [2:0] hsize;
  logic [15:0] base_strap;
  logic hreadyout;
  logic hresp;
  logic [31:0] hrdata;
  logic irq;
  logic led_out;
  logic [31:0] rd;
  int n_fail = 0;
  int checks = 0;
  int cyc = 0;
  int n_rf = 0;
  wdt_if link();
  wdt_device #(.HALF_CYCLES(20), .BLINK_CYCLES(4), .PULSE_CYCLES(4))
    wdt_device_inst (.core_clk(core_clk), .rst(rst), .io(link),
    .base_port(base_strap), .led_out(led_out));
  wdt_host wdt_host_inst (.core_clk(core_clk), .rst(rst), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .irq(irq), .io(link));
  wdt_checker #(.HALF_CYCLES(20)) wdt_checker_inst (.core_clk(core_clk),
    .rst(rst), .io_addr(link.io_addr), .io_wdata(link.io_wdata),
    .io_wr(link.io_wr), .wd_irq(link.wd_irq), .wd_reset(link.wd_reset));
  initial
  begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end
  // Run length is a few thousand cycles; the ceiling leaves ample room
  always @(posedge core_clk)
  begin
    cyc <= cyc + 1;
    if ($rose(link.wd_reset))
      n_rf <= n_rf + 1;
    if (cyc == 30000)
    begin
      n_fail++;
      stop_test();
    end
  end
  // ********************
  // Shared tasks
  // ********************
  task automatic stop_test();
    if (n_fail == 0 && checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] s,
    input logic [31:0] e);
    checks++;
    if (s !== e)
    begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic ahb(input logic w, input logic [7:0] a,
    input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    hwrite <= w;
    hsize <= 3'h2;
    htrans <= 2'h2;
    do @(posedge core_clk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge core_clk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  // Bit 8 picks the alternate port; returns at the edge of the strobe
  task automatic fac(input logic [8:0] f);
    ahb(1'b1, REG_CMD, {23'h0, f});
    do @(posedge core_clk); while (link.io_wr !== 1'b1);
    chk("io_addr", link.io_addr, f[8] ? 32'h104 : 32'h76);
    chk("io_wdata", link.io_wdata, f[7:0]);
  endtask
  task automatic run_out(input int units, input logic use_irq);
    int t0;
    int on;
    logic seen;
    t0 = cyc;
    on = 0;
    seen = 1'b0;
    while (seen !== 1'b1)
    begin
      @(posedge core_clk);
      seen = use_irq ? link.wd_irq : link.wd_reset;
      if (led_out === 1'b1)
        on++;
    end
    chk("expiry", cyc - t0, 20 * units + 1);
    chk("blink", on > 0 && on < cyc - t0, 1);
    repeat (6) @(posedge core_clk);
    chk("led_after", led_out, 1'b0);
  endtask
  // ********************
  // Scenarios
  // ********************
  task automatic t_reset();
    logic [7:0] regs [5] = '{REG_BASE, REG_STATUS, REG_MASK, REG_LAST,
      8'h14};
    ahb(1'b1, 8'h14, 32'hffffffff);
    foreach (regs[i])
    begin
      ahb(1'b0, regs[i], 32'h0);
      chk("reg_reset", rd, 32'h0);
    end
    repeat (100) @(posedge core_clk);
    chk("idle", {link.wd_irq, link.wd_reset, led_out, irq}, 0);
    chk("hresp", hresp, 1'b0);
  endtask
  task automatic t_modes();
    ahb(1'b1, REG_MASK, 32'h2);
    for (int c = 0; c < 16; c++)
    begin
      if (c > 7)
        fac(9'h000);
      fac({2'b01, c > 7, 3'h0, c[2:0]});
      if (c > 7)
      begin
        @(posedge core_clk);
        chk("irq_enable", link.wd_irq, 1'b1);
        fac({1'b0, 5'h18, c[2:0]});
      end
      run_out(c[2:0] == 0 ? 1 : 2 * c[2:0], c > 7);
      ahb(1'b0, REG_STATUS, 32'h0);
      chk("status", rd, c > 7 ? 32'h5 : 32'h6);
      // Mask passes only the reset bit
      chk("irq_out", irq, c < 8);
      ahb(1'b1, REG_STATUS, 32'h7);
      ahb(1'b0, REG_STATUS, 32'h0);
      chk("status_clear", rd, 32'h0);
      chk("irq_clear", irq, 1'b0);
    end
    fac(9'h000);
    @(posedge core_clk);
    chk("irq_cleared", link.wd_irq, 1'b0);
  endtask
  task automatic t_trigger();
    logic [8:0] bad [5] = '{9'h100, 9'h188, 9'h140, 9'h1ff, 9'h0c8};
    int k;
    k = n_rf;
    ahb(1'b1, REG_BASE, 32'h100);
    ahb(1'b0, REG_BASE, 32'h0);
    chk("base", rd, 32'h100);
    fac(9'h081);
    ahb(1'b0, REG_LAST, 32'h0);
    chk("last", rd, 32'h81);
    repeat (4)
    begin
      repeat (25) @(posedge core_clk);
      fac(9'h081);
    end
    chk("no_fire", n_rf, k);
    fac(9'h180);
    run_out(1, 1'b0);
    k = n_rf;
    foreach (bad[i])
    begin
      fac(9'h080);
      fac(bad[i]);
      repeat (60) @(posedge core_clk);
      chk("stopped", n_rf, k);
      chk("stopped_led", led_out, 1'b0);
      chk("stopped_irq", link.wd_irq, 1'b0);
    end
  endtask
  task automatic t_rerun();
    int k;
    k = n_rf;
    fac(9'h0c0);
    rst <= 1'b1;
    repeat (3) @(posedge core_clk);
    rst <= 1'b0;
    repeat (60) @(posedge core_clk);
    chk("reset_off", n_rf, k);
    chk("reset_led", led_out, 1'b0);
    chk("reset_irq", link.wd_irq, 1'b0);
  endtask
  initial
  begin
    rst = 1'b1;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hwdata = 32'h0;
    hsize = 3'h2;
    base_strap = 16'h0100;
    repeat (5) @(posedge core_clk);
    rst <= 1'b0;
    t_reset();
    t_modes();
    t_trigger();
    t_rerun();
    stop_test();
  end
endmodule
